//--- verilog/flc_config_control.sv
// control and configuration of the frequency locked loop
// Notes on behaviour
// - reference from master, bit clock or oscillator
// - loop runs only while enable bit set
// - predivider 1, 2 or 4, reset code 01
// - output ratio equals divider code plus one
// - oscillator equals reference times N.K times ratio
// - vco ratio decodes 1, 2, 4, 8, 16
// - integer multiplier used in both modes
// - fraction applied only in fractional mode
// - numerator and denominator are 16-bit integers
//
// Strobed register access was chosen for this implementation.
`include "flc_defines.svh"
`default_nettype none
module flc_config_control (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire flc_pkg::flc_bus_req_t busReq,
	output logic [15:0] busRdata_q,
	// reference pins
	input wire logic mclkPin,
	input wire logic bclkPin,
	input wire logic oscPin,
	// loop controls
	output flc_pkg::flc_loop_cfg_t loopCfg_q,
	output logic loopRefTick_q,
	output logic [15:0] loopTarget_q,
	output logic loopTargetStrobe_q,
	output logic systemClockGate_q
);
	import flc_pkg::*;

	logic [15:0] ctrl1_q;
	logic [15:0] ctrl2_q;
	logic [15:0] ctrl3_q;
	logic [15:0] ctrl4_q;
	logic [15:0] numer_q;
	logic [15:0] denom_q;
	logic [15:0] intMul_q;
	logic [15:0] refSel_q;
	logic loopEnable;
	logic fracMode;
	logic [2:0] ratioShift;
	logic [4:0] ratioSteps;
	logic [15:0] baseNow;
	logic refTick;
	flc_state_t state_q;
	logic [4:0] stepsLeft_q;
	logic [16:0] acc_q;
	logic [4:0] carry_q;
	logic [15:0] base_q;
	logic [16:0] accSum;
	logic carryNow;
	logic [4:0] carryNext;
	logic pubValid;
	logic [15:0] pubValue;

	assign loopEnable = ctrl1_q[`FLC_ENA_BIT];
	assign fracMode = ctrl1_q[`FLC_FRAC_BIT];
	assign ratioShift = flc_ratio_shift(ctrl3_q[`FLC_RATIO_MSB:`FLC_RATIO_LSB]);
	assign ratioSteps = 5'(5'h01 << ratioShift);
	assign baseNow = 16'(ctrl1_q[0] ? intMul_q[`FLC_INTMUL_MSB:0] : 10'h000) << ratioShift;

	// reference select and predivider
	flc_ref_divider refDiv (
		.clk(clk),
		.sys_rst(sys_rst),
		.mclkPin(mclkPin),
		.bclkPin(bclkPin),
		.oscPin(oscPin),
		.refSelect(refSel_q[`FLC_REFSEL_MSB:0]),
		.predivCode(ctrl2_q[`FLC_PREDIV_MSB:`FLC_PREDIV_LSB]),
		.loopEnable(loopEnable),
		.refTick(refTick)
	);

	// register writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl1_q <= `FLC_RST_CTRL1;
			ctrl2_q <= `FLC_RST_CTRL2;
			ctrl3_q <= `FLC_RST_CTRL3;
			ctrl4_q <= `FLC_RST_CTRL4;
			numer_q <= `FLC_RST_NUMER;
			denom_q <= `FLC_RST_DENOM;
			intMul_q <= `FLC_RST_INTMUL;
			refSel_q <= `FLC_RST_REFSEL;
		end else if (busReq.wr) begin
			unique case (busReq.addr)
				`FLC_OFS_CTRL1: ctrl1_q <= busReq.wdata & `FLC_MASK_CTRL1;
				`FLC_OFS_CTRL2: ctrl2_q <= busReq.wdata & `FLC_MASK_CTRL2;
				`FLC_OFS_CTRL3: ctrl3_q <= busReq.wdata & `FLC_MASK_CTRL3;
				`FLC_OFS_CTRL4: ctrl4_q <= busReq.wdata & `FLC_MASK_CTRL4;
				`FLC_OFS_NUMER: numer_q <= busReq.wdata;
				`FLC_OFS_DENOM: denom_q <= busReq.wdata;
				`FLC_OFS_INTMUL: intMul_q <= busReq.wdata & `FLC_MASK_INTMUL;
				`FLC_OFS_REFSEL: refSel_q <= busReq.wdata & `FLC_MASK_REFSEL;
				default: begin
				end
			endcase
		end
	end

	// register reads, data valid in the following cycle only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busRdata_q <= 16'h0000;
		end else if (busReq.rd) begin
			unique case (busReq.addr)
				`FLC_OFS_CTRL1: busRdata_q <= ctrl1_q;
				`FLC_OFS_CTRL2: busRdata_q <= ctrl2_q;
				`FLC_OFS_CTRL3: busRdata_q <= ctrl3_q;
				`FLC_OFS_CTRL4: busRdata_q <= ctrl4_q;
				`FLC_OFS_NUMER: busRdata_q <= numer_q;
				`FLC_OFS_DENOM: busRdata_q <= denom_q;
				`FLC_OFS_INTMUL: busRdata_q <= intMul_q;
				`FLC_OFS_REFSEL: busRdata_q <= refSel_q;
				`FLC_OFS_STATUS: busRdata_q <= {14'h0000, systemClockGate_q, loopCfg_q.active};
				`FLC_OFS_TARGET: busRdata_q <= loopTarget_q;
				default: busRdata_q <= 16'h0000;
			endcase
		end else begin
			busRdata_q <= 16'h0000;
		end
	end

	// fractional accumulation step
	always_comb begin
		accSum = acc_q + {1'b0, numer_q};
		carryNow = (denom_q != 16'h0000) && (accSum >= {1'b0, denom_q});
		carryNext = carry_q + {4'h0, carryNow};
	end

	// multiplier sequencer
	always_ff @(posedge clk) begin
		if (sys_rst || !loopEnable) begin
			state_q <= FLC_IDLE;
			stepsLeft_q <= 5'h00;
			acc_q <= 17'h0_0000;
			carry_q <= 5'h00;
			base_q <= 16'h0000;
		end else begin
			unique case (state_q)
				FLC_IDLE: begin
					if (refTick && fracMode && denom_q != 16'h0000) begin
						state_q <= FLC_ACCUM;
						stepsLeft_q <= ratioSteps - 5'h01;
						carry_q <= 5'h00;
						base_q <= baseNow;
					end
				end
				FLC_ACCUM: begin
					acc_q <= carryNow ? accSum - {1'b0, denom_q} : accSum;
					carry_q <= carryNext;
					stepsLeft_q <= stepsLeft_q - 5'h01;
					if (stepsLeft_q == 5'h00) begin
						state_q <= FLC_IDLE;
					end
				end
			endcase
		end
	end

	// publish the per-reference target count
	always_comb begin
		pubValid = 1'b0;
		pubValue = baseNow;
		if (loopEnable && state_q == FLC_IDLE && refTick && !(fracMode && denom_q != 16'h0000)) begin
			pubValid = 1'b1;
		end else if (loopEnable && state_q == FLC_ACCUM && stepsLeft_q == 5'h00) begin
			pubValid = 1'b1;
			pubValue = base_q + {11'h000, carryNext};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			loopTarget_q <= 16'h0000;
			loopTargetStrobe_q <= 1'b0;
		end else begin
			loopTargetStrobe_q <= pubValid;
			if (pubValid) begin
				loopTarget_q <= pubValue;
			end
		end
	end

	// configuration outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			loopCfg_q <= '0;
			loopRefTick_q <= 1'b0;
		end else begin
			loopCfg_q.outDivRatio <= {1'b0, ctrl2_q[`FLC_OUTDIV_MSB:`FLC_OUTDIV_LSB]} + 7'h01;
			loopCfg_q.fracMode <= fracMode;
			loopCfg_q.active <= loopEnable;
			loopRefTick_q <= refTick;
		end
	end

	// system clock gate
	always_ff @(posedge clk) begin
		if (sys_rst || !loopEnable) begin
			systemClockGate_q <= 1'b0;
		end else if (pubValid) begin
			systemClockGate_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_enable_reset_low: assert property (disable iff (1'b0)
		$past(sys_rst) |-> !loopCfg_q.active && !systemClockGate_q)
		else $error("loop active right after reset");
	chk_active_follows_bit: assert property (
		loopEnable |=> loopCfg_q.active)
		else $error("active output does not follow enable bit");
	chk_outdiv_ratio: assert property (
		1'b1 |=> loopCfg_q.outDivRatio ==
			{1'b0, $past(ctrl2_q[`FLC_OUTDIV_MSB:`FLC_OUTDIV_LSB])} + 7'h01)
		else $error("output ratio is not code plus one");
	chk_ratio_top_bit: assert property (
		ctrl3_q[`FLC_RATIO_MSB] |-> ratioSteps == 5'h10)
		else $error("vco ratio code 1xx does not give sixteen");
	chk_integer_target: assert property (
		(loopEnable && state_q == FLC_IDLE && refTick && !fracMode)
			|=> loopTargetStrobe_q && loopTarget_q == $past(baseNow))
		else $error("integer target not published next cycle");
	chk_fraction_latency: assert property (disable iff (sys_rst || !loopEnable)
		(loopEnable && state_q == FLC_IDLE && refTick && fracMode && denom_q != 16'h0000)
			|=> (state_q == FLC_ACCUM) ##[1:17] loopTargetStrobe_q)
		else $error("fractional target not published within ratio steps");
	chk_carry_bound: assert property (
		(loopTargetStrobe_q && $past(state_q) == FLC_ACCUM)
			|-> loopTarget_q >= base_q && loopTarget_q <= base_q + 16'h0010)
		else $error("target count outside base plus ratio");
	chk_gate_off_disabled: assert property (
		!loopEnable |=> !systemClockGate_q)
		else $error("system clock gate open while disabled");
	chk_numer_readback: assert property (
		(busReq.rd && busReq.addr == `FLC_OFS_NUMER) |=> busRdata_q == $past(numer_q))
		else $error("numerator readback mismatch");
	chk_read_one_cycle: assert property (
		!busReq.rd |=> busRdata_q == 16'h0000)
		else $error("read data outside read slot");

	// register port checks
	chk_ctrl1_masked: assert property (
		(busReq.wr && busReq.addr == `FLC_OFS_CTRL1)
			|=> ctrl1_q == ($past(busReq.wdata) & `FLC_MASK_CTRL1))
		else $error("control one write not masked");
	chk_ctrl2_masked: assert property (
		(busReq.wr && busReq.addr == `FLC_OFS_CTRL2)
			|=> ctrl2_q == ($past(busReq.wdata) & `FLC_MASK_CTRL2))
		else $error("control two write not masked");
	chk_ctrl3_masked: assert property (
		(busReq.wr && busReq.addr == `FLC_OFS_CTRL3)
			|=> ctrl3_q == ($past(busReq.wdata) & `FLC_MASK_CTRL3))
		else $error("control three write not masked");
	chk_intmul_masked: assert property (
		(busReq.wr && busReq.addr == `FLC_OFS_INTMUL)
			|=> intMul_q == ($past(busReq.wdata) & `FLC_MASK_INTMUL))
		else $error("integer multiplier write not masked");
	chk_refsel_masked: assert property (
		(busReq.wr && busReq.addr == `FLC_OFS_REFSEL)
			|=> refSel_q == ($past(busReq.wdata) & `FLC_MASK_REFSEL))
		else $error("reference select write not masked");
	chk_numer_write: assert property (
		(busReq.wr && busReq.addr == `FLC_OFS_NUMER)
			|=> numer_q == $past(busReq.wdata))
		else $error("numerator write lost");
	chk_denom_write: assert property (
		(busReq.wr && busReq.addr == `FLC_OFS_DENOM)
			|=> denom_q == $past(busReq.wdata))
		else $error("denominator write lost");
	chk_regs_hold: assert property (
		!busReq.wr |=> $stable(numer_q) && $stable(denom_q) && $stable(intMul_q))
		else $error("multiplier registers changed without a write");
	chk_status_read: assert property (
		(busReq.rd && busReq.addr == `FLC_OFS_STATUS) |=> busRdata_q ==
			{14'h0000, $past(systemClockGate_q), $past(loopCfg_q.active)})
		else $error("status readback mismatch");

	// ratio decode and sequencer checks
	chk_ratio_low_codes: assert property (
		!ctrl3_q[`FLC_RATIO_MSB] |-> ratioSteps == (ctrl3_q[1:0] == 2'h0 ? 5'h01 :
			ctrl3_q[1:0] == 2'h1 ? 5'h02 : ctrl3_q[1:0] == 2'h2 ? 5'h04 : 5'h08))
		else $error("vco ratio low code decoded wrongly");
	chk_base_ratio_one: assert property (
		(loopEnable && ctrl3_q[`FLC_RATIO_MSB:`FLC_RATIO_LSB] == 3'h0)
			|-> baseNow == {6'h00, intMul_q[`FLC_INTMUL_MSB:0]})
		else $error("integer base is not N at ratio one");
	chk_base_disabled: assert property (
		!loopEnable |-> baseNow == 16'h0000)
		else $error("integer base present while disabled");
	chk_int_no_accum: assert property (
		(state_q == FLC_IDLE && !fracMode) |=> state_q == FLC_IDLE)
		else $error("accumulation started in integer mode");
	chk_disable_clears: assert property (
		!loopEnable |=> state_q == FLC_IDLE && acc_q == 17'h0_0000)
		else $error("sequencer not cleared while disabled");
	chk_accum_ends: assert property (
		(state_q == FLC_ACCUM && stepsLeft_q == 5'h00) |=> state_q == FLC_IDLE)
		else $error("accumulation overran its ratio steps");
	chk_acc_below_denom: assert property (
		(state_q == FLC_ACCUM && numer_q < denom_q && acc_q < {1'b0, denom_q})
			|=> acc_q < {1'b0, $past(denom_q)})
		else $error("accumulator left the fraction range");

	// output checks
	chk_tick_echo: assert property (
		1'b1 |=> loopRefTick_q == $past(refTick))
		else $error("reference tick not echoed one cycle later");
	chk_frac_out: assert property (
		1'b1 |=> loopCfg_q.fracMode == $past(fracMode))
		else $error("fractional mode output does not follow bit");
	chk_target_holds: assert property (
		!loopTargetStrobe_q |-> $stable(loopTarget_q))
		else $error("target count changed without strobe");
	chk_gate_needs_target: assert property (
		$rose(systemClockGate_q) |-> loopTargetStrobe_q)
		else $error("system clock gate opened without a target");

	cov_integer_publish: cover property (
		loopTargetStrobe_q && !loopCfg_q.fracMode);
	cov_fraction_carry: cover property (
		state_q == FLC_ACCUM && carryNow);
	cov_gate_opens: cover property (
		$rose(systemClockGate_q));
	cov_ratio_sixteen: cover property (
		loopTargetStrobe_q && ratioSteps == 5'h10);
endmodule
`default_nettype wire

//--- inc/flc_defines.svh
// register offsets, field positions, write masks and reset values of the loop control block
`ifndef FLC_DEFINES_SVH
`define FLC_DEFINES_SVH

`define FLC_OFS_CTRL1 8'h9b
`define FLC_OFS_CTRL2 8'h9c
`define FLC_OFS_CTRL3 8'h9d
`define FLC_OFS_CTRL4 8'h9e
`define FLC_OFS_NUMER 8'ha0
`define FLC_OFS_DENOM 8'ha1
`define FLC_OFS_INTMUL 8'ha2
`define FLC_OFS_REFSEL 8'ha3
`define FLC_OFS_STATUS 8'ha4
`define FLC_OFS_TARGET 8'ha5

`define FLC_ENA_BIT 0
`define FLC_FRAC_BIT 2
`define FLC_OUTDIV_MSB 8
`define FLC_OUTDIV_LSB 3
`define FLC_PREDIV_MSB 1
`define FLC_PREDIV_LSB 0
`define FLC_RATIO_MSB 2
`define FLC_RATIO_LSB 0
`define FLC_INTMUL_MSB 9
`define FLC_REFSEL_MSB 1

`define FLC_MASK_CTRL1 16'h000d
`define FLC_MASK_CTRL2 16'h01fb
`define FLC_MASK_CTRL3 16'h01f7
`define FLC_MASK_CTRL4 16'h000f
`define FLC_MASK_INTMUL 16'h03ff
`define FLC_MASK_REFSEL 16'h0003

`define FLC_RST_CTRL1 16'h000c
`define FLC_RST_CTRL2 16'h0039
`define FLC_RST_CTRL3 16'h0180
`define FLC_RST_CTRL4 16'h0000
`define FLC_RST_NUMER 16'h0018
`define FLC_RST_DENOM 16'h007d
`define FLC_RST_INTMUL 16'h0008
`define FLC_RST_REFSEL 16'h0000

`endif

//--- inc/flc_pkg.sv
// types and decode functions of the loop control block
`default_nettype none
package flc_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} flc_bus_req_t;

	typedef struct packed {
		logic [6:0] outDivRatio;
		logic fracMode;
		logic active;
	} flc_loop_cfg_t;

	typedef enum logic {FLC_IDLE, FLC_ACCUM} flc_state_t;

	// vco ratio code to shift count
	function automatic logic [2:0] flc_ratio_shift(input logic [2:0] code);
		logic [2:0] s;
		s = 3'h4;
		if (!code[2]) begin
			s = {1'b0, code[1:0]};
		end
		return s;
	endfunction

	// predivider code to divisor, reserved code held at four
	function automatic logic [2:0] flc_predivide(input logic [1:0] code);
		logic [2:0] d;
		d = 3'h4;
		if (code == 2'h0) begin
			d = 3'h1;
		end else if (code == 2'h1) begin
			d = 3'h2;
		end
		return d;
	endfunction
endpackage
`default_nettype wire

//--- verilog/flc_ref_divider.sv
// reference source select, pin synchronisers and reference predivider
`default_nettype none
module flc_ref_divider (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// reference pins
	input wire logic mclkPin,
	input wire logic bclkPin,
	input wire logic oscPin,
	// control
	input wire logic [1:0] refSelect,
	input wire logic [1:0] predivCode,
	input wire logic loopEnable,
	// divided reference
	output logic refTick
);
	import flc_pkg::*;

	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] sync3_q;
	logic [2:0] edges;
	logic edgeSel;
	logic [1:0] divCnt_q;
	logic [2:0] divisor;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
		end else begin
			sync1_q <= {oscPin, bclkPin, mclkPin};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign edges = sync2_q & ~sync3_q;
	assign divisor = flc_predivide(predivCode);

	always_comb begin
		unique case (refSelect)
			2'h0: edgeSel = edges[0];
			2'h1: edgeSel = edges[1];
			2'h2: edgeSel = edges[2];
			2'h3: edgeSel = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst || !loopEnable) begin
			divCnt_q <= 2'h0;
			refTick <= 1'b0;
		end else if (edgeSel) begin
			if (divCnt_q == 2'(divisor - 3'h1)) begin
				divCnt_q <= 2'h0;
				refTick <= 1'b1;
			end else begin
				divCnt_q <= divCnt_q + 2'h1;
				refTick <= 1'b0;
			end
		end else begin
			refTick <= 1'b0;
		end
	end

	chk_tick_needs_enable: assert property (@(posedge clk) disable iff (sys_rst)
		refTick |-> $past(loopEnable))
		else $error("reference tick while loop disabled");
	chk_tick_from_select: assert property (@(posedge clk) disable iff (sys_rst)
		refTick |-> $past(edgeSel))
		else $error("reference tick without selected edge");
	chk_predivide_two: assert property (@(posedge clk) disable iff (sys_rst)
		(refTick && predivCode == 2'h1 && $stable(predivCode)) |=> (!refTick)[*3])
		else $error("divide by two ticks too close");
	chk_predivide_four: assert property (@(posedge clk) disable iff (sys_rst)
		(refTick && predivCode == 2'h2 && $stable(predivCode)) |=> (!refTick)[*7])
		else $error("divide by four ticks too close");
endmodule
`default_nettype wire

//--- verification/flc_ref_source.sv
// free-running reference sources at the far side of the loop control block
`default_nettype none
module flc_ref_source #(
	parameter int HALF_MCLK = 100,
	parameter int HALF_BCLK = 140,
	parameter int HALF_OSC = 180
) (
	// reference pins
	output logic mclkPin,
	output logic bclkPin,
	output logic oscPin
);
	timeunit 1ns;
	timeprecision 1ps;
	// rates kept low enough that every divided reference stays in range
	initial begin
		mclkPin = 1'b0;
		#7 forever #HALF_MCLK mclkPin = ~mclkPin;
	end
	initial begin
		bclkPin = 1'b0;
		#13 forever #HALF_BCLK bclkPin = ~bclkPin;
	end
	initial begin
		oscPin = 1'b0;
		#29 forever #HALF_OSC oscPin = ~oscPin;
	end
endmodule
`default_nettype wire

//--- verification/flc_config_control_test.sv
// self-checking bench of the loop control block
`default_nettype none
module flc_config_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import flc_pkg::*;
	logic clk;
	logic sys_rst;
	flc_bus_req_t busReq;
	logic [15:0] busRdata_q;
	logic mclkPin;
	logic bclkPin;
	logic oscPin;
	flc_loop_cfg_t loopCfg_q;
	logic loopRefTick_q;
	logic [15:0] loopTarget_q;
	logic loopTargetStrobe_q;
	logic systemClockGate_q;
	int n_mismatch = 0;
	int compares = 0;
	int seed = 62;
	int nEdge[3] = '{0, 0, 0};
	flc_ref_source u_src (.mclkPin(mclkPin), .bclkPin(bclkPin), .oscPin(oscPin));
	flc_config_control u_dut (.clk(clk), .sys_rst(sys_rst), .busReq(busReq),
		.busRdata_q(busRdata_q), .mclkPin(mclkPin), .bclkPin(bclkPin), .oscPin(oscPin),
		.loopCfg_q(loopCfg_q), .loopRefTick_q(loopRefTick_q), .loopTarget_q(loopTarget_q),
		.loopTargetStrobe_q(loopTargetStrobe_q), .systemClockGate_q(systemClockGate_q));
	always @(posedge mclkPin) nEdge[0]++;
	always @(posedge bclkPin) nEdge[1]++;
	always @(posedge oscPin) nEdge[2]++;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		busReq.wr <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		busReq.rd <= 1'b0;
		#1;
		chk(what, exp, busRdata_q);
	endtask
	// waits for a target strobe or a reference tick
	task automatic wait_hi(input logic strobe);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if ((strobe ? loopTargetStrobe_q : loopRefTick_q) === 1'b1) break;
		end
		if (i == 300) begin
			chk("strobe wait", 16'h0001, 16'h0000);
		end
	endtask
	function automatic int ratio_of(input int code);
		return code >= 4 ? 16 : (1 << code);
	endfunction
	function automatic int prediv_of(input int code);
		return code == 0 ? 1 : (code == 1 ? 2 : 4);
	endfunction
	task automatic setup(input int src, input int pd, input int rc, input int n, input logic fr);
		wr(8'h9b, {13'h0001, fr, 2'h0});
		wr(8'ha3, 16'(src));
		wr(8'h9c, 16'h0038 | 16'(pd));
		wr(8'h9d, 16'h0180 | 16'(rc));
		wr(8'ha2, 16'(n));
		wr(8'h9b, {13'h0001, fr, 2'h1});
	endtask
	task automatic give_verdict();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#1ms;
		n_mismatch++;
		$display("wrong value watchdog expected finish seen timeout");
		give_verdict();
	end
	initial begin
		int i, j, n, acc, cy;
		logic [15:0] v;
		busReq = '0;
		sys_rst = 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk("r9b", 8'h9b, 16'h000c);
		rdchk("r9c", 8'h9c, 16'h0039);
		rdchk("r9d", 8'h9d, 16'h0180);
		rdchk("r9e", 8'h9e, 16'h0000);
		rdchk("ra0", 8'ha0, 16'h0018);
		rdchk("ra1", 8'ha1, 16'h007d);
		rdchk("ra2", 8'ha2, 16'h0008);
		rdchk("unmapped", 8'h50, 16'h0000);
		for (i = 0; i < 4; i++) begin
			v = 16'($random(seed));
			wr(8'ha0, v);
			wr(8'ha1, ~v);
			wr(8'ha2, v);
			rdchk("ra0", 8'ha0, v);
			rdchk("ra1", 8'ha1, ~v);
			rdchk("ra2", 8'ha2, v & 16'h03ff);
		end
		foreach (nEdge[k]) begin
			v = 16'(k == 0 ? 1 : (k == 1 ? 7 : 47));
			wr(8'h9c, (v << 3) | 16'h0001);
			repeat (2) @(posedge clk);
			#1;
			chk("out ratio", v + 16'h0001, {9'h000, loopCfg_q.outDivRatio});
		end
		$display("test registers done");
		for (i = 0; i < 4; i++) begin
			for (j = 0; j < 3; j++) begin
				setup(i, j, 0, 8, 1'b0);
				rdchk("ra3", 8'ha3, 16'(i));
				if (i < 3) begin
					wait_hi(1'b0);
					wait_hi(1'b0);
					n = nEdge[i];
					wait_hi(1'b0);
					chk("edges per tick", 16'(prediv_of(j)), 16'(nEdge[i] - n));
				end else begin
					n = 0;
					repeat (60) begin
						@(posedge clk);
						#1;
						if (loopRefTick_q !== 1'b0) n++;
					end
					chk("no source ticks", 16'h0000, 16'(n));
				end
			end
		end
		$display("test reference done");
		for (i = 0; i < 8; i++) begin
			n = int'($random(seed)) & 32'h0000_03ff;
			setup(0, 1, i, n, 1'b0);
			@(posedge clk);
			#1;
			chk("active", 16'h0001, {15'h0000, loopCfg_q.active});
			chk("frac mode", 16'h0000, {15'h0000, loopCfg_q.fracMode});
			wait_hi(1'b1);
			chk("int target", 16'(n * ratio_of(i)), loopTarget_q);
			chk("gate", 16'h0001, {15'h0000, systemClockGate_q});
			rdchk("target", 8'ha5, 16'(n * ratio_of(i)));
			rdchk("status", 8'ha4, 16'h0003);
		end
		$display("test integer done");
		wr(8'h9b, 16'h000c);
		wr(8'ha0, 16'h0018);
		wr(8'ha1, 16'h007d);
		for (i = 0; i < 3; i++) begin
			setup(1, 0, i, 8, 1'b1);
			@(posedge clk);
			#1;
			chk("frac mode", 16'h0001, {15'h0000, loopCfg_q.fracMode});
			acc = 0;
			for (j = 0; j < 7; j++) begin
				cy = 0;
				repeat (ratio_of(i)) begin
					acc += 24;
					if (acc >= 125) begin
						acc -= 125;
						cy++;
					end
				end
				wait_hi(1'b1);
				chk("frac target", 16'((8 << i) + cy), loopTarget_q);
			end
		end
		$display("test fraction done");
		wr(8'h9b, 16'h000c);
		repeat (2) @(posedge clk);
		#1;
		chk("gate off", 16'h0000, {15'h0000, systemClockGate_q});
		chk("inactive", 16'h0000, {15'h0000, loopCfg_q.active});
		n = 0;
		repeat (200) begin
			@(posedge clk);
			#1;
			if (loopTargetStrobe_q !== 1'b0 || loopRefTick_q !== 1'b0 || systemClockGate_q !== 1'b0) n++;
		end
		chk("pulses off", 16'h0000, 16'(n));
		$display("test disable done");
		give_verdict();
	end
endmodule
`default_nettype wire
